// ===== verilog/eces_pkg.sv
/*
 * Shared constants and carrier types for the E1 receive event-status block.
 * Assumes one 100 MHz clock and framer strobes synchronous to it.
 */
package eces_pkg;

    localparam int unsigned ECES_AW       = 12;
    localparam int unsigned ECES_DW       = 8;
    localparam int unsigned ECES_NCHAN    = 30;
    localparam int unsigned ECES_NSA      = 5;
    localparam int unsigned ECES_ABCD_W   = 4;
    localparam int unsigned ECES_CHAN_W   = 5;
    localparam int unsigned ECES_CNT_W    = 3;

    // Register offsets within the block's 12-bit address space
    localparam logic [11:0] ECES_OFS_FRMCTL = 12'h10B;
    localparam logic [11:0] ECES_OFS_SIG0  = 12'h10D;
    localparam logic [11:0] ECES_OFS_SIG1  = 12'h10E;
    localparam logic [11:0] ECES_OFS_SIG2  = 12'h10F;
    localparam logic [11:0] ECES_OFS_SIG3  = 12'h110;
    localparam logic [11:0] ECES_OFS_STAT  = 12'hB04;
    localparam logic [11:0] ECES_OFS_MASK  = 12'hB05;

    // Field positions
    localparam int unsigned ECES_BIT_CASMF = 7;
    localparam int unsigned ECES_BIT_NAT   = 6;
    localparam int unsigned ECES_BIT_SIG   = 5;
    localparam int unsigned ECES_THR_LSB   = 5;
    localparam int unsigned ECES_THR_W     = 2;

    // Reset values
    localparam logic [7:0] ECES_RST_STAT  = 8'h00;
    localparam logic [7:0] ECES_RST_MASK  = 8'h00;
    localparam logic [7:0] ECES_RST_FRMCTL = 8'h00;
    localparam logic [7:0] ECES_STAT_USED = 8'hE0;

    // Multiframe alignment signal strobe: one pulse per received signal
    typedef struct packed {
        logic valid;
        logic err;
    } eces_mf_t;

    // Sa4..Sa8 of a received non-FAS frame, bit 0 is Sa4
    typedef struct packed {
        logic                 valid;
        logic [ECES_NSA-1:0]  sa;
    } eces_nat_t;

    // ABCD bits of one voice channel, chan 0..29
    typedef struct packed {
        logic                    valid;
        logic [ECES_CHAN_W-1:0]  chan;
        logic [ECES_ABCD_W-1:0]  abcd;
    } eces_sig_t;

endpackage : eces_pkg

// ===== verilog/eces_cas_mf.sv
/*
 * CAS multiframe alignment loss monitor.
 * Assumes one strobe per received alignment signal, on the system clock.
 */
`timescale 1ns/1ps
module eces_cas_mf
    import eces_pkg::*;
(
    input  wire logic                  sys_clk_in,
    input  wire logic                  srst_in,
    input  wire eces_mf_t              mf_in,
    input  wire logic [ECES_THR_W-1:0] thresh_in,
    output logic                       loss_out,
    output logic                       change_out
);

    logic [ECES_CNT_W-1:0] err_cnt_q;
    logic [ECES_CNT_W-1:0] need;
    logic [ECES_CNT_W-1:0] cnt_inc;

    // Field value n asks for n+1 consecutive bad signals, so 0 is never "never"
    assign need    = ECES_CNT_W'(thresh_in) + 3'h1;
    assign cnt_inc = err_cnt_q + 3'h1;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            err_cnt_q <= 3'h0;
        end else if (mf_in.valid) begin
            if (!mf_in.err) begin
                err_cnt_q <= 3'h0;
            end else if (err_cnt_q != 3'h7) begin
                err_cnt_q <= cnt_inc;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            loss_out   <= 1'b0;
            change_out <= 1'b0;
        end else begin
            change_out <= 1'b0;
            if (mf_in.valid && mf_in.err && !loss_out && cnt_inc >= need) begin
                loss_out   <= 1'b1;
                change_out <= 1'b1;
            end else if (mf_in.valid && !mf_in.err && loss_out) begin
                loss_out   <= 1'b0;
                change_out <= 1'b1;
            end
        end
    end

endmodule : eces_cas_mf

// ===== verilog/eces_top.sv
/*
 * Receive event-status logic: CAS multiframe, national bit and
 * signaling change flags, per-channel change map and interrupt.
 * Assumes framer strobes on sys_clk_in and a single-cycle register port.
 */
//
// Operation
// - Set bit 7 when CAS multiframe alignment loss is declared or cleared.
// - Declare CAS loss after programmed consecutive bad signals, control bits 6-5.
// - Set bit 6 when any of Sa4-Sa8 in non-FAS frames changes.
// - Set bit 5 when any ABCD bit changes in any of 30 channels.
// - Keep per-channel signaling change bits readable in their own registers.
// - Flags read 1 after an event, clear on read, reset to 0.
// - Interrupt raised only for flags whose enable is set.
`timescale 1ns/1ps
module eces_top
    import eces_pkg::*;
(
    input  wire logic               sys_clk_in,
    input  wire logic               srst_in,
    input  wire logic [ECES_AW-1:0] addr_in,
    input  wire logic [ECES_DW-1:0] wdata_in,
    input  wire logic               wr_in,
    input  wire logic               rd_in,
    input  wire eces_mf_t           mf_in,
    input  wire eces_nat_t          nat_in,
    input  wire eces_sig_t          sig_in,
    output logic [ECES_DW-1:0]      rdata_out,
    output logic                    irq_out,
    output logic                    cas_loss_out
);

    logic [ECES_DW-1:0]      frmctl_q;
    logic [ECES_DW-1:0]      mask_q;
    logic [ECES_DW-1:0]      stat_q;
    logic [ECES_DW-1:0]      stat_d;
    logic [ECES_DW-1:0]      stat_set;
    logic [ECES_DW-1:0]      stat_clr;

    logic [ECES_NSA-1:0]     sa_q;
    logic                    sa_seen_q;
    logic                    nat_evt;

    logic [31:0]             chg_q;
    logic [31:0]             chg_clr;
    logic [ECES_NCHAN-1:0]   chg_evt;
    logic                    sig_evt;

    logic                    mf_change;
    logic                    mf_loss;

    logic                    wr_frmctl;
    logic                    wr_mask;
    logic                    wr_stat;
    logic                    rd_stat;
    logic [3:0]              rd_sig;

    // Address decode

    assign wr_frmctl = wr_in && (addr_in == ECES_OFS_FRMCTL);
    assign wr_mask = wr_in && (addr_in == ECES_OFS_MASK);
    assign wr_stat = wr_in && (addr_in == ECES_OFS_STAT);
    assign rd_stat = rd_in && (addr_in == ECES_OFS_STAT);

    assign rd_sig[0] = rd_in && (addr_in == ECES_OFS_SIG0);
    assign rd_sig[1] = rd_in && (addr_in == ECES_OFS_SIG1);
    assign rd_sig[2] = rd_in && (addr_in == ECES_OFS_SIG2);
    assign rd_sig[3] = rd_in && (addr_in == ECES_OFS_SIG3);

    // Control registers

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            frmctl_q <= ECES_RST_FRMCTL;
        end else if (wr_frmctl) begin
            frmctl_q <= wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            mask_q <= ECES_RST_MASK;
        end else if (wr_mask) begin
            mask_q <= wdata_in & ECES_STAT_USED;
        end
    end

    // CAS multiframe alignment monitor

    eces_cas_mf u_cas_mf (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .mf_in      (mf_in),
        .thresh_in  (frmctl_q[ECES_THR_LSB +: ECES_THR_W]),
        .loss_out   (mf_loss),
        .change_out (mf_change)
    );

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            cas_loss_out <= 1'b0;
        end else begin
            cas_loss_out <= mf_loss;
        end
    end

    // National bits: the first frame after reset only primes the copy,
    // so a power-up value is not reported as a change

    assign nat_evt = nat_in.valid && sa_seen_q && (nat_in.sa != sa_q);

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            sa_q      <= 5'h00;
            sa_seen_q <= 1'b0;
        end else if (nat_in.valid) begin
            sa_q      <= nat_in.sa;
            sa_seen_q <= 1'b1;
        end
    end

    // Per-channel ABCD copies and change bits

    genvar ch;
    generate
        for (ch = 0; ch < ECES_NCHAN; ch++) begin : g_chan
            logic [ECES_ABCD_W-1:0] abcd_q;
            logic                   seen_q;
            logic                   hit;

            assign hit         = sig_in.valid && (sig_in.chan == ECES_CHAN_W'(ch));
            assign chg_evt[ch] = hit && seen_q && (sig_in.abcd != abcd_q);

            always_ff @(posedge sys_clk_in) begin
                if (srst_in) begin
                    abcd_q <= 4'h0;
                    seen_q <= 1'b0;
                end else if (hit) begin
                    abcd_q <= sig_in.abcd;
                    seen_q <= 1'b1;
                end
            end

            always_ff @(posedge sys_clk_in) begin
                if (srst_in) begin
                    chg_q[ch] <= 1'b0;
                end else if (chg_evt[ch]) begin
                    chg_q[ch] <= 1'b1;
                end else if (chg_clr[ch]) begin
                    chg_q[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    // Two spare positions in the last change register stay zero
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            chg_q[31:ECES_NCHAN] <= 2'h0;
        end else begin
            chg_q[31:ECES_NCHAN] <= 2'h0;
        end
    end

    assign chg_clr = {{8{rd_sig[3]}}, {8{rd_sig[2]}}, {8{rd_sig[1]}}, {8{rd_sig[0]}}};

    assign sig_evt = |chg_evt;

    // Event status: set has priority over any clear in the same cycle

    always_comb begin
        stat_set                 = 8'h00;
        stat_set[ECES_BIT_CASMF] = mf_change;
        stat_set[ECES_BIT_NAT]   = nat_evt;
        stat_set[ECES_BIT_SIG]   = sig_evt;
    end

    // Read clears everything shown; writing a one also clears that bit
    always_comb begin
        stat_clr = 8'h00;
        if (rd_stat) begin
            stat_clr = 8'hFF;
        end
        if (wr_stat) begin
            stat_clr = stat_clr | wdata_in;
        end
    end

    assign stat_d = ((stat_q & ~stat_clr) | stat_set) & ECES_STAT_USED;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            stat_q <= ECES_RST_STAT;
        end else begin
            stat_q <= stat_d;
        end
    end

    // Interrupt follows the status one cycle later
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(stat_q & mask_q);
        end
    end

    // Read data: valid only in the cycle after the read strobe

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                ECES_OFS_FRMCTL: begin
                    rdata_out <= frmctl_q;
                end
                ECES_OFS_MASK: begin
                    rdata_out <= mask_q;
                end
                ECES_OFS_STAT: begin
                    rdata_out <= stat_q;
                end
                ECES_OFS_SIG0: begin
                    rdata_out <= chg_q[7:0];
                end
                ECES_OFS_SIG1: begin
                    rdata_out <= chg_q[15:8];
                end
                ECES_OFS_SIG2: begin
                    rdata_out <= chg_q[23:16];
                end
                ECES_OFS_SIG3: begin
                    rdata_out <= chg_q[31:24];
                end
                default: begin
                    rdata_out <= 8'h00;
                end
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

endmodule : eces_top

// ===== bench/eces_top_properties.sv
/* Port assertions for the receive event-status block.
   Assumes binding to eces_top, one clock, synchronous reset. */
`timescale 1ns/1ps
module eces_top_properties
    import eces_pkg::*;
(
    input wire logic               sys_clk_in,
    input wire logic               srst_in,
    input wire logic [ECES_AW-1:0] addr_in,
    input wire logic [ECES_DW-1:0] wdata_in,
    input wire logic               wr_in,
    input wire logic               rd_in,
    input wire eces_mf_t           mf_in,
    input wire eces_nat_t          nat_in,
    input wire eces_sig_t          sig_in,
    input wire logic [ECES_DW-1:0] rdata_out,
    input wire logic               irq_out,
    input wire logic               cas_loss_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    logic [7:0] mask_q;
    logic [4:0] sa_q;
    logic       prim_q;
    always_ff @(posedge sys_clk_in) begin
        if (srst_in)
            mask_q <= 8'h00;
        else if (wr_in && addr_in == ECES_OFS_MASK)
            mask_q <= wdata_in & ECES_STAT_USED;
    end
    // First national frame only primes the compare
    always_ff @(posedge sys_clk_in) begin
        if (nat_in.valid)
            sa_q <= nat_in.sa;
        prim_q <= !srst_in && (prim_q || nat_in.valid);
    end
    sequence stat_rd; rd_in && addr_in == ECES_OFS_STAT; endsequence
    sequence quiet; !mf_in.valid && !nat_in.valid && !sig_in.valid; endsequence
    sequence nat_chg; nat_in.valid && prim_q && nat_in.sa != sa_q; endsequence
    cas_timing_a: assert property ($changed(cas_loss_out) && !$past(srst_in)
        |-> $past(mf_in.valid, 2)) else $error("cas loss moved without strobe");
    cas_clear_a: assert property (mf_in.valid && !mf_in.err && cas_loss_out
        |-> ##2 !cas_loss_out) else $error("good strobe kept cas loss");
    cas_flag_a: assert property ($changed(cas_loss_out) && !$past(srst_in)
        && mask_q[ECES_BIT_CASMF] |=> irq_out) else $error("cas change gave no irq");
    nat_flag_a: assert property (nat_chg ##1 stat_rd
        |=> rdata_out[ECES_BIT_NAT]) else $error("national change not flagged");
    read_clear_a: assert property (quiet ##1 (stat_rd ##0 quiet) ##1 stat_rd
        |=> rdata_out == 8'h00) else $error("status not cleared by read");
    stat_unused_a: assert property (stat_rd
        |=> (rdata_out & ~ECES_STAT_USED) == 8'h00) else $error("unused status bit set");
    sig_top_a: assert property (rd_in && addr_in == ECES_OFS_SIG3
        |=> rdata_out[7:6] == 2'b00) else $error("channel map bits 7:6 set");
    irq_mask_a: assert property ((mask_q == 8'h00) [*3] |-> !irq_out)
        else $error("irq with all enables clear");
endmodule : eces_top_properties

bind eces_top eces_top_properties u_props (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .mf_in(mf_in),
    .nat_in(nat_in), .sig_in(sig_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .cas_loss_out(cas_loss_out));

// ===== bench/eces_framer_model.sv
/* Receive framer stand-in driving the event strobes.
   Assumes one call at a time per strobe kind. */
`timescale 1ns/1ps
module eces_framer_model
    import eces_pkg::*;
(
    input  wire logic sys_clk_in,
    output eces_mf_t   mf_out,
    output eces_nat_t  nat_out,
    output eces_sig_t  sig_out
);
    initial {mf_out, nat_out, sig_out} = '0;
    // Idle fields carry inverted data so stale values cannot pass
    task automatic mf(input logic e);
        @(posedge sys_clk_in) mf_out <= '{1'b1, e};
        @(posedge sys_clk_in) mf_out <= '{1'b0, ~e};
    endtask : mf
    task automatic nat(input logic [4:0] s);
        @(posedge sys_clk_in) nat_out <= '{1'b1, s};
        @(posedge sys_clk_in) nat_out <= '{1'b0, ~s};
    endtask : nat
    task automatic sig(input logic [4:0] c, input logic [3:0] v);
        @(posedge sys_clk_in) sig_out <= '{1'b1, c, v};
        @(posedge sys_clk_in) sig_out <= '{1'b0, ~c, ~v};
    endtask : sig
endmodule : eces_framer_model

// ===== bench/eces_top_test.sv
/* Self-checking bench for eces_top against an integer model.
   Assumes eces_framer_model stands in for the receive framer. */
`timescale 1ns/1ps
module eces_top_test
    import eces_pkg::*;
;
    logic        sys_clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic [11:0] addr = '0;
    logic [7:0]  wdata = '0, rdata;
    logic        wr_s = 1'b0, rd_s = 1'b0, irq, loss_pin;
    eces_mf_t    mf;
    eces_nat_t   nb;
    eces_sig_t   sg;
    int          n_mismatch = 0, samples_checked = 0, cyc = 0, k, m;
    int          fctl = 0, mask = 0, stat = 0, loss = 0, errs = 0, lsa = -1;
    int          labcd [30] = '{default: -1};
    logic [7:0]  schg [4] = '{default: 8'h00};
    logic [11:0] amap [8] = '{ECES_OFS_FRMCTL, ECES_OFS_SIG0, ECES_OFS_SIG1, ECES_OFS_SIG2,
                              ECES_OFS_SIG3, ECES_OFS_STAT, ECES_OFS_MASK, 12'h123};
    eces_framer_model fm (.sys_clk_in(sys_clk_in), .mf_out(mf), .nat_out(nb), .sig_out(sg));
    eces_top dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .mf_in(mf), .nat_in(nb),
        .sig_in(sg), .rdata_out(rdata), .irq_out(irq), .cas_loss_out(loss_pin));
    always #5 sys_clk_in = ~sys_clk_in;
    // Model read: returns the value and applies clear-on-read
    function automatic logic [7:0] mv(input logic [11:0] a);
        logic [7:0] v;
        v = (a == ECES_OFS_FRMCTL) ? fctl[7:0] : (a == ECES_OFS_MASK) ? mask[7:0] : 8'h00;
        if (a == ECES_OFS_STAT) begin
            v = stat[7:0];
            stat = 0;
        end
        for (int i = 0; i < 4; i++) if (a == ECES_OFS_SIG0 + i) begin
            v = schg[i];
            schg[i] = 8'h00;
        end
        return v;
    endfunction : mv
    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask : chk_reg
    task automatic chk_pin(input string nm, input logic e, input logic s);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s exp %b got %b", nm, e, s);
        end
    endtask : chk_pin
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge sys_clk_in);
        wr_s <= 1'b0;
        if (a == ECES_OFS_FRMCTL) fctl = d;
        if (a == ECES_OFS_MASK) mask = d & ECES_STAT_USED;
        if (a == ECES_OFS_STAT) stat &= ~d;
    endtask : wr
    // Expected value taken at drive time, so a same-edge event stays out of it
    task automatic rd(input logic [11:0] a, input int n);
        logic [7:0] e;
        @(posedge sys_clk_in);
        addr <= a;
        rd_s <= 1'b1;
        for (int j = n; j > 0; j--) begin
            e = mv(a);
            @(posedge sys_clk_in);
            if (j == 1) rd_s <= 1'b0;
            #1 chk_reg("rdata_out", e, rdata);
        end
    endtask : rd
    task automatic ev(input int t, input int v, input int ch);
        fork
            if (t == 0) fm.mf(v[0]);
            else if (t == 1) fm.nat(v[4:0]);
            else fm.sig(ch[4:0], v[3:0]);
            begin
                @(posedge sys_clk_in);
                #1;
                errs = (t != 0) ? errs : v[0] ? errs + 1 : 0;
                if (t == 0 && (loss == 0 && errs == fctl[6:5] + 1 || loss == 1 && errs == 0)) begin
                    loss ^= 1;
                    stat |= 8'h80;
                end
                if (t == 1 && lsa >= 0 && lsa != v[4:0]) stat |= 8'h40;
                if (t == 2 && labcd[ch] >= 0 && labcd[ch] != v[3:0]) begin
                    stat |= 8'h20;
                    schg[ch / 8][ch % 8] = 1'b1;
                end
                if (t == 1) lsa = v[4:0];
                if (t == 2) labcd[ch] = v[3:0];
            end
        join
    endtask : ev
    task automatic settle;
        repeat (4) @(posedge sys_clk_in);
        // Look after the edge has settled the registered pins
        #1;
        chk_pin("irq_out", (stat & mask) != 0, irq);
        chk_pin("cas_loss_out", loss[0], loss_pin);
    endtask : settle
    task automatic results;
        $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    // Run needs about 1400 cycles; the ceiling leaves ample margin
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        void'($urandom(32'hAE65));
        repeat (20) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        foreach (amap[i]) rd(amap[i], 1);
        wr(12'h123, 8'hFF);
        wr(ECES_OFS_MASK, 8'hFF);
        for (int t = 0; t < 4; t++) begin
            wr(ECES_OFS_FRMCTL, 8'(t << 5));
            rd(ECES_OFS_FRMCTL, 1);
            repeat (t) ev(0, 1, 0);
            settle();
            ev(0, 1, 0);
            settle();
            ev(0, 0, 0);
            settle();
            rd(ECES_OFS_STAT, 2);
        end
        // Flags are judged with no CAS-enable gating, which is left to software
        for (int i = 0; i < 200; i++) begin
            k = $urandom % 3;
            m = (k == 0) ? 0 : $urandom % 3;
            if (i == 100) wr(ECES_OFS_MASK, 8'h00);
            fork
                ev(k, $urandom % 32, $urandom % 30);
                if (m > 0) begin
                    repeat (m - 1) @(posedge sys_clk_in);
                    rd(ECES_OFS_STAT, 1);
                end
            join
            settle();
            if (i == 150) wr(ECES_OFS_STAT, 8'h60);
        end
        foreach (amap[i]) rd(amap[i], 1);
        rd(ECES_OFS_STAT, 2);
        results();
    end
endmodule : eces_top_test
